// >>> hdl/lcrb_config_bank.v
// Notes on behaviour
// - Monitor code: low zero idle, else line+1
// - Digital loopback turns transmit rails to receive
// - Digital plus remote loopback gives dual loopback
// - Criteria bit picks E1 rule; T1 fixed
// - Auto all-ones sent while loss detected
// - All-ones timed from master reference tick
// - Global bit 7 selects internal receive impedance
// - External mode trims except E1 120 ohm or template bit 7 set
// - Global bit 6 forces alarm on loss
// - Global bit 5 disables short protection everywhere
// - Global bit 4 forces AMI on all
// - Global bit 3 forces 128-bit attenuator depth
// - Global bit 1 forces attenuator into receive
// - Global bit 0 enables attenuator on all
// - Pointer 000..111 selects template channel 1..8
// - Template bit 7 turns receive match off
// - Template bit 6 turns transmit termination off
// - Template bit 3 picks impedance per variant
// - Template code picks mode and length
// - Monitor code in low four bits
// - Remote loopback returns line to transmitter
`timescale 1ns/1ps
`default_nettype none
`include "lcrb_regs.vh"

module lcrb_config_bank #(
  parameter NCH = 8,
  parameter DEFAULT_120 = 1
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Host register port
  input wire [7:0] addr_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output reg rd_hit_o,
  // Settings held elsewhere in the device
  input wire [NCH-1:0] remote_loopback_bits_i,
  input wire [NCH-1:0] per_channel_alarm_on_loss_i,
  input wire [NCH-1:0] per_channel_short_protect_off_i,
  input wire [NCH-1:0] per_channel_line_code_i,
  input wire [NCH-1:0] per_channel_ja_depth_i,
  input wire [NCH-1:0] per_channel_ja_position_i,
  input wire [NCH-1:0] per_channel_ja_enable_i,
  // Line status and reference pacing
  input wire [NCH-1:0] los_i,
  input wire mclk_tick_i,
  // System rails (pins)
  input wire [NCH-1:0] tx_pos_rail_i,
  input wire [NCH-1:0] tx_neg_rail_i,
  output wire [NCH-1:0] rx_pos_rail_o,
  output wire [NCH-1:0] rx_neg_rail_o,
  // Line front end data
  input wire [NCH-1:0] line_rx_pos_i,
  input wire [NCH-1:0] line_rx_neg_i,
  output wire [NCH-1:0] line_tx_pos_o,
  output wire [NCH-1:0] line_tx_neg_o,
  // Monitoring selection
  output reg mon_active_o,
  output reg mon_tx_line_o,
  output reg [3:0] mon_line_o,
  // Loopback and alarm controls
  output reg [NCH-1:0] dig_loop_o,
  output reg [NCH-1:0] dual_loop_o,
  output reg [NCH-1:0] crit_ets_o,
  output reg [NCH-1:0] crit_g775_o,
  output reg [NCH-1:0] crit_t1_o,
  output reg [NCH-1:0] all_ones_active_o,
  // Effective global or per-channel settings
  output reg rx_imp_internal_o,
  output reg [NCH-1:0] alarm_on_loss_o,
  output reg [NCH-1:0] short_protect_off_o,
  output reg [NCH-1:0] ami_select_o,
  output reg [NCH-1:0] ja_depth_128_o,
  output reg [NCH-1:0] ja_rx_path_o,
  output reg [NCH-1:0] ja_enable_o,
  // Per-channel template results
  output reg [NCH-1:0] e1_mode_o,
  output reg [NCH-1:0] imp_120_o,
  output reg [NCH-1:0] rx_match_off_o,
  output reg [NCH-1:0] rx_trim_o,
  output reg [NCH-1:0] tx_term_off_o,
  output reg [NCH-1:0] tmpl_reserved_o,
  output reg [3*NCH-1:0] tmpl_code_o
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [3:0] line_monitor_select_q;
  reg [7:0] digital_loopback_bits_q;
  reg [7:0] los_alarm_criteria_bits_q;
  reg [7:0] auto_all_ones_bits_q;
  reg [7:0] global_settings_q;
  reg [2:0] template_channel_pointer_q;
  reg [7:0] line_template_code_q [0:NCH-1];
  reg [NCH-1:0] tx_pos_s1_q, tx_pos_s2_q;
  reg [NCH-1:0] tx_neg_s1_q, tx_neg_s2_q;
  reg [NCH-1:0] los_s1_q, los_s2_q;
  reg [NCH-1:0] lrx_pos_s1_q, lrx_pos_s2_q;
  reg [NCH-1:0] lrx_neg_s1_q, lrx_neg_s2_q;
  reg [7:0] rdata_d;
  reg rd_hit_d;
  wire mon_act_w;
  wire mon_tx_w;
  wire [3:0] mon_line_w;
  integer i;
  integer k;

  // Template code for a copy, used by the per-channel decode; readback returns the whole copy
  function [2:0] tcode;
    input [7:0] t;
    begin
      tcode = t[`LCRB_TS_CODE_HI:0];
    end
  endfunction

  // E1 impedance of a copy is 120 ohm per the variant and the alternate bit
  function is_120;
    input [7:0] t;
    begin
      if (DEFAULT_120 != 0) begin
        is_120 = ~t[`LCRB_TS_IMP_ALT];
      end else begin
        is_120 = t[`LCRB_TS_IMP_ALT];
      end
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Rails and loss flags come from outside this clock, two stages each
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_pos_s1_q <= {NCH{1'b0}};
      tx_pos_s2_q <= {NCH{1'b0}};
      tx_neg_s1_q <= {NCH{1'b0}};
      tx_neg_s2_q <= {NCH{1'b0}};
      los_s1_q <= {NCH{1'b0}};
      los_s2_q <= {NCH{1'b0}};
      lrx_pos_s1_q <= {NCH{1'b0}};
      lrx_pos_s2_q <= {NCH{1'b0}};
      lrx_neg_s1_q <= {NCH{1'b0}};
      lrx_neg_s2_q <= {NCH{1'b0}};
    end else begin
      tx_pos_s1_q <= tx_pos_rail_i;
      tx_pos_s2_q <= tx_pos_s1_q;
      tx_neg_s1_q <= tx_neg_rail_i;
      tx_neg_s2_q <= tx_neg_s1_q;
      los_s1_q <= los_i;
      los_s2_q <= los_s1_q;
      lrx_pos_s1_q <= line_rx_pos_i;
      lrx_pos_s2_q <= lrx_pos_s1_q;
      lrx_neg_s1_q <= line_rx_neg_i;
      lrx_neg_s2_q <= lrx_neg_s1_q;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Masks drop reserved bits so they always read back as zero
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_monitor_select_q <= `LCRB_RST_MON;
      digital_loopback_bits_q <= `LCRB_RST_BYTE;
      los_alarm_criteria_bits_q <= `LCRB_RST_BYTE;
      auto_all_ones_bits_q <= `LCRB_RST_BYTE;
      global_settings_q <= `LCRB_RST_BYTE;
      template_channel_pointer_q <= `LCRB_RST_PTR;
      for (k = 0; k < NCH; k = k + 1) begin
        line_template_code_q[k] <= `LCRB_RST_BYTE;
      end
    end else if (wr_en_i) begin
      if (addr_i == `LCRB_ADDR_MON_CTRL) begin
        line_monitor_select_q <= wdata_i[3:0];
      end else if (addr_i == `LCRB_ADDR_DLB) begin
        digital_loopback_bits_q <= wdata_i;
      end else if (addr_i == `LCRB_ADDR_LAC) begin
        los_alarm_criteria_bits_q <= wdata_i;
      end else if (addr_i == `LCRB_ADDR_AAO) begin
        auto_all_ones_bits_q <= wdata_i;
      end else if (addr_i == `LCRB_ADDR_GLB) begin
        global_settings_q <= wdata_i & `LCRB_GLB_WMASK;
      end else if (addr_i == `LCRB_ADDR_TPTR) begin
        template_channel_pointer_q <= wdata_i[2:0];
      end else if (addr_i == `LCRB_ADDR_TSEL) begin
        // Only the copy named by the pointer changes
        line_template_code_q[template_channel_pointer_q] <= wdata_i & `LCRB_TS_WMASK;
      end
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Unknown addresses belong to other banks: zero data, hit low
  always @* begin
    rdata_d = 8'h00;
    rd_hit_d = 1'b1;
    if (addr_i == `LCRB_ADDR_MON_CTRL) begin
      rdata_d = {4'h0, line_monitor_select_q};
    end else if (addr_i == `LCRB_ADDR_DLB) begin
      rdata_d = digital_loopback_bits_q;
    end else if (addr_i == `LCRB_ADDR_LAC) begin
      rdata_d = los_alarm_criteria_bits_q;
    end else if (addr_i == `LCRB_ADDR_AAO) begin
      rdata_d = auto_all_ones_bits_q;
    end else if (addr_i == `LCRB_ADDR_GLB) begin
      rdata_d = global_settings_q;
    end else if (addr_i == `LCRB_ADDR_TPTR) begin
      rdata_d = {5'h00, template_channel_pointer_q};
    end else if (addr_i == `LCRB_ADDR_TSEL) begin
      rdata_d = line_template_code_q[template_channel_pointer_q];
    end else begin
      rd_hit_d = 1'b0;
    end
  end

  // Read data held until the next read
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
      rd_hit_o <= 1'b0;
    end else if (rd_en_i) begin
      rdata_o <= rdata_d;
      rd_hit_o <= rd_hit_d;
    end
  end

  // ----------------------------------------
  // Monitor selection
  // ----------------------------------------
  lcrb_mon_decode u_mon (
    .code_i(line_monitor_select_q),
    .mon_active_o(mon_act_w),
    .mon_tx_line_o(mon_tx_w),
    .mon_line_o(mon_line_w)
  );

  // Registered so the front-end switch sees a clean change
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mon_active_o <= 1'b0;
      mon_tx_line_o <= 1'b0;
      mon_line_o <= 4'h0;
    end else begin
      mon_active_o <= mon_act_w;
      mon_tx_line_o <= mon_tx_w;
      mon_line_o <= mon_line_w;
    end
  end

  // ----------------------------------------
  // Effective per-channel controls
  // ----------------------------------------
  // A global bit overrides; when clear the per-channel source decides
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dig_loop_o <= {NCH{1'b0}};
      dual_loop_o <= {NCH{1'b0}};
      crit_ets_o <= {NCH{1'b0}};
      crit_g775_o <= {NCH{1'b0}};
      crit_t1_o <= {NCH{1'b0}};
      all_ones_active_o <= {NCH{1'b0}};
      rx_imp_internal_o <= 1'b0;
      alarm_on_loss_o <= {NCH{1'b0}};
      short_protect_off_o <= {NCH{1'b0}};
      ami_select_o <= {NCH{1'b0}};
      ja_depth_128_o <= {NCH{1'b0}};
      ja_rx_path_o <= {NCH{1'b0}};
      ja_enable_o <= {NCH{1'b0}};
      e1_mode_o <= {NCH{1'b0}};
      imp_120_o <= {NCH{1'b0}};
      rx_match_off_o <= {NCH{1'b0}};
      rx_trim_o <= {NCH{1'b0}};
      tx_term_off_o <= {NCH{1'b0}};
      tmpl_reserved_o <= {NCH{1'b0}};
      tmpl_code_o <= {3*NCH{1'b0}};
    end else begin
      dig_loop_o <= digital_loopback_bits_q[NCH-1:0];
      dual_loop_o <= digital_loopback_bits_q[NCH-1:0] & remote_loopback_bits_i;
      all_ones_active_o <= auto_all_ones_bits_q[NCH-1:0] & los_s2_q;
      rx_imp_internal_o <= global_settings_q[`LCRB_GLB_RX_IMP_MODE];
      alarm_on_loss_o <= global_settings_q[`LCRB_GLB_ALARM_ALL] ?
                         {NCH{1'b1}} : per_channel_alarm_on_loss_i;
      short_protect_off_o <= global_settings_q[`LCRB_GLB_SHORT_OFF_ALL] ?
                             {NCH{1'b1}} : per_channel_short_protect_off_i;
      ami_select_o <= global_settings_q[`LCRB_GLB_AMI_ALL] ?
                      {NCH{1'b1}} : per_channel_line_code_i;
      ja_depth_128_o <= global_settings_q[`LCRB_GLB_JA_DEPTH_ALL] ?
                        {NCH{1'b1}} : per_channel_ja_depth_i;
      ja_rx_path_o <= global_settings_q[`LCRB_GLB_JA_POS_ALL] ?
                      {NCH{1'b1}} : per_channel_ja_position_i;
      ja_enable_o <= global_settings_q[`LCRB_GLB_JA_EN_ALL] ?
                     {NCH{1'b1}} : per_channel_ja_enable_i;
      for (i = 0; i < NCH; i = i + 1) begin
        // E1 only on code 000; 011 and up are T1/J1 lengths; 001, 010 reserved
        e1_mode_o[i] <= (tcode(line_template_code_q[i]) == `LCRB_TS_CODE_E1);
        tmpl_reserved_o[i] <= (tcode(line_template_code_q[i]) == `LCRB_TS_CODE_RSVD_A) ||
                              (tcode(line_template_code_q[i]) == `LCRB_TS_CODE_RSVD_B);
        tmpl_code_o[3*i +: 3] <= tcode(line_template_code_q[i]);
        // Criteria bit matters in E1 only; T1/J1 always uses its own rule
        crit_ets_o[i] <= (tcode(line_template_code_q[i]) == `LCRB_TS_CODE_E1) &
                         los_alarm_criteria_bits_q[i];
        crit_g775_o[i] <= (tcode(line_template_code_q[i]) == `LCRB_TS_CODE_E1) &
                          ~los_alarm_criteria_bits_q[i];
        crit_t1_o[i] <= (tcode(line_template_code_q[i]) != `LCRB_TS_CODE_E1);
        imp_120_o[i] <= is_120(line_template_code_q[i]);
        rx_match_off_o[i] <= line_template_code_q[i][`LCRB_TS_RX_MATCH_OFF];
        tx_term_off_o[i] <= line_template_code_q[i][`LCRB_TS_TX_TERM_OFF];
        // External mode still trims, except E1 at 120 ohm which needs none, and channels with receive match off
        rx_trim_o[i] <= ~global_settings_q[`LCRB_GLB_RX_IMP_MODE] &
                        ~line_template_code_q[i][`LCRB_TS_RX_MATCH_OFF] &
                        ~((tcode(line_template_code_q[i]) == `LCRB_TS_CODE_E1) &
                          is_120(line_template_code_q[i]));
      end
    end
  end

  // ----------------------------------------
  // Data path loops
  // ----------------------------------------
  // Fed from the registered digital loop and all-ones controls and the remote loop input, so a change lands one cycle later
  lcrb_rail_path #(
    .NCH(NCH)
  ) u_rail (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .dlb_i(dig_loop_o),
    .rlb_i(remote_loopback_bits_i),
    .all_ones_i(all_ones_active_o),
    .mclk_tick_i(mclk_tick_i),
    .tx_pos_i(tx_pos_s2_q),
    .tx_neg_i(tx_neg_s2_q),
    .line_rx_pos_i(lrx_pos_s2_q),
    .line_rx_neg_i(lrx_neg_s2_q),
    .rx_pos_o(rx_pos_rail_o),
    .rx_neg_o(rx_neg_rail_o),
    .line_tx_pos_o(line_tx_pos_o),
    .line_tx_neg_o(line_tx_neg_o)
  );

endmodule

`default_nettype wire

// >>> hdl/lcrb_regs.vh
`ifndef LCRB_REGS_VH
`define LCRB_REGS_VH

// ----------------------------------------
// Register offsets (8-bit host interface)
// ----------------------------------------
`define LCRB_ADDR_MON_CTRL 8'h0b
`define LCRB_ADDR_DLB 8'h0c
`define LCRB_ADDR_LAC 8'h0d
`define LCRB_ADDR_AAO 8'h0e
`define LCRB_ADDR_GLB 8'h0f
`define LCRB_ADDR_TPTR 8'h10
`define LCRB_ADDR_TSEL 8'h11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCRB_RST_BYTE 8'h00
`define LCRB_RST_MON 4'h0
`define LCRB_RST_PTR 3'h0

// ----------------------------------------
// Global settings bit positions
// ----------------------------------------
`define LCRB_GLB_RX_IMP_MODE 7
`define LCRB_GLB_ALARM_ALL 6
`define LCRB_GLB_SHORT_OFF_ALL 5
`define LCRB_GLB_AMI_ALL 4
`define LCRB_GLB_JA_DEPTH_ALL 3
`define LCRB_GLB_JA_POS_ALL 1
`define LCRB_GLB_JA_EN_ALL 0
`define LCRB_GLB_WMASK 8'hfb

// ----------------------------------------
// Template register fields
// ----------------------------------------
`define LCRB_TS_RX_MATCH_OFF 7
`define LCRB_TS_TX_TERM_OFF 6
`define LCRB_TS_IMP_ALT 3
`define LCRB_TS_CODE_HI 2
`define LCRB_TS_WMASK 8'hcf
`define LCRB_TS_CODE_E1 3'h0
`define LCRB_TS_CODE_T1_SHORT 3'h3
`define LCRB_TS_CODE_RSVD_A 3'h1
`define LCRB_TS_CODE_RSVD_B 3'h2

// ----------------------------------------
// Pointer and monitor fields
// ----------------------------------------
`define LCRB_PTR_WMASK 8'h07
`define LCRB_MON_WMASK 8'h0f

`endif

// >>> hdl/lcrb_mon_decode.v
`timescale 1ns/1ps
`default_nettype none

module lcrb_mon_decode (
  // Select code
  input wire [3:0] code_i,
  // Decoded selection
  output wire mon_active_o,
  output wire mon_tx_line_o,
  output wire [3:0] mon_line_o
);

  // ----------------------------------------
  // Monitor code decode
  // ----------------------------------------
  // Low bits zero means idle regardless of the direction bit
  assign mon_active_o = (code_i[2:0] != 3'h0);
  // Line number is low bits plus one, so 2..8; receiver 1 does the monitoring
  assign mon_line_o = mon_active_o ? ({1'b0, code_i[2:0]} + 4'h1) : 4'h0;
  assign mon_tx_line_o = mon_active_o & code_i[3];

endmodule

`default_nettype wire

// >>> hdl/lcrb_rail_path.v
`timescale 1ns/1ps
`default_nettype none

module lcrb_rail_path #(
  parameter NCH = 8
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_n_i,
  // Per-channel controls
  input wire [NCH-1:0] dlb_i,
  input wire [NCH-1:0] rlb_i,
  input wire [NCH-1:0] all_ones_i,
  input wire mclk_tick_i,
  // Rails, already synchronised
  input wire [NCH-1:0] tx_pos_i,
  input wire [NCH-1:0] tx_neg_i,
  input wire [NCH-1:0] line_rx_pos_i,
  input wire [NCH-1:0] line_rx_neg_i,
  // Outputs
  output reg [NCH-1:0] rx_pos_o,
  output reg [NCH-1:0] rx_neg_o,
  output reg [NCH-1:0] line_tx_pos_o,
  output reg [NCH-1:0] line_tx_neg_o
);

  reg ones_phase_q;

  // ----------------------------------------
  // All-ones mark alternation
  // ----------------------------------------
  // Paced by the master reference tick, since the system transmit clock may be gone
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ones_phase_q <= 1'b0;
    end else if (mclk_tick_i) begin
      ones_phase_q <= ~ones_phase_q;
    end
  end

  // ----------------------------------------
  // Loopback and line muxes
  // ----------------------------------------
  // Both loops may be active together, which gives dual loopback per channel
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_pos_o <= {NCH{1'b0}};
      rx_neg_o <= {NCH{1'b0}};
      line_tx_pos_o <= {NCH{1'b0}};
      line_tx_neg_o <= {NCH{1'b0}};
    end else begin
      // System receive side: transmit rails turned round when digitally looped
      rx_pos_o <= (dlb_i & tx_pos_i) | (~dlb_i & line_rx_pos_i);
      rx_neg_o <= (dlb_i & tx_neg_i) | (~dlb_i & line_rx_neg_i);
      // Line side: all-ones wins, then remote loop, then system data
      line_tx_pos_o <= (all_ones_i & {NCH{ones_phase_q}}) |
                       (~all_ones_i & rlb_i & line_rx_pos_i) |
                       (~all_ones_i & ~rlb_i & tx_pos_i);
      line_tx_neg_o <= (all_ones_i & {NCH{~ones_phase_q}}) |
                       (~all_ones_i & rlb_i & line_rx_neg_i) |
                       (~all_ones_i & ~rlb_i & tx_neg_i);
    end
  end

endmodule

`default_nettype wire

// >>> testbench/lcrb_config_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none

module lcrb_config_bank_chk #(
  parameter NCH = 8
) (
  // Clock, reset and host port
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic rd_hit_o,
  // Rails and derived controls
  input wire logic [NCH-1:0] remote_loopback_bits_i,
  input wire logic mclk_tick_i,
  input wire logic [NCH-1:0] tx_pos_rail_i,
  input wire logic [NCH-1:0] line_rx_pos_i,
  input wire logic [NCH-1:0] rx_pos_rail_o,
  input wire logic [NCH-1:0] line_tx_pos_o,
  input wire logic [NCH-1:0] line_tx_neg_o,
  input wire logic mon_active_o,
  input wire logic [3:0] mon_line_o,
  input wire logic [NCH-1:0] dig_loop_o,
  input wire logic [NCH-1:0] dual_loop_o,
  input wire logic [NCH-1:0] all_ones_active_o
);
  // Low code bits, named so $past sees a plain signal
  wire logic [2:0] wr_code = wdata_i[2:0];

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Monitor write followed by a quiet cycle, so the stored code is not replaced
  sequence mon_wr;
    wr_en_i && addr_i == 8'h0b;
  endsequence
  sequence mon_settle;
    mon_wr ##1 !(wr_en_i && addr_i == 8'h0b);
  endsequence
  sequence rd_at(logic [7:0] a);
    rd_en_i && addr_i == a;
  endsequence

  chk_mon_code_decode: assert property (mon_settle |=> mon_active_o == ($past(wr_code, 2) != 3'h0) &&
    mon_line_o == (($past(wr_code, 2) == 3'h0) ? 4'h0 : 4'h1 + $past(wr_code, 2)))
    else $error("monitor selection does not follow the written code");
  chk_glb_rsvd_zero: assert property (rd_at(8'h0f) |=> rdata_o[2] == 1'b0 && rd_hit_o)
    else $error("global reserved bit reads nonzero");
  chk_ptr_rsvd_zero: assert property (rd_at(8'h10) |=> rdata_o[7:3] == 5'h00 && rd_hit_o)
    else $error("pointer reserved bits read nonzero");
  chk_tmpl_rsvd_zero: assert property (rd_at(8'h11) |=> rdata_o[5:4] == 2'h0 && rd_hit_o)
    else $error("template reserved bits read nonzero");
  chk_dig_loop_rails: assert property ((dig_loop_o == 8'hff)[*4] |-> rx_pos_rail_o == $past(tx_pos_rail_i, 3))
    else $error("receive rails do not carry looped transmit rails");
  chk_remote_loop_line: assert property ((remote_loopback_bits_i == 8'hff && all_ones_active_o == 8'h00)[*5]
    |-> line_tx_pos_o == $past(line_rx_pos_i, 3))
    else $error("line transmit does not carry looped receive data");
  chk_dual_loop_subset: assert property (dual_loop_o == (dig_loop_o & $past(remote_loopback_bits_i)))
    else $error("dual loopback not digital and remote loopback together");
  chk_ones_polarity: assert property ((all_ones_active_o == 8'hff)[*2] |-> line_tx_neg_o == ~line_tx_pos_o)
    else $error("all-ones rails not complementary");
  chk_ones_mclk_pace: assert property ((all_ones_active_o == 8'hff && !mclk_tick_i)[*3] |-> $stable(line_tx_pos_o))
    else $error("all-ones phase moved without a reference tick");
  chk_ones_tick_step: assert property ((all_ones_active_o == 8'hff)[*2] ##0 mclk_tick_i
    |-> ##[1:2] line_tx_pos_o != $past(line_tx_pos_o))
    else $error("all-ones phase did not advance on a reference tick");
endmodule

bind lcrb_config_bank lcrb_config_bank_chk #(.NCH(NCH)) u_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .wdata_i(wdata_i), .rdata_o(rdata_o), .rd_hit_o(rd_hit_o), .remote_loopback_bits_i(remote_loopback_bits_i),
  .mclk_tick_i(mclk_tick_i), .tx_pos_rail_i(tx_pos_rail_i), .line_rx_pos_i(line_rx_pos_i),
  .rx_pos_rail_o(rx_pos_rail_o), .line_tx_pos_o(line_tx_pos_o), .line_tx_neg_o(line_tx_neg_o),
  .mon_active_o(mon_active_o), .mon_line_o(mon_line_o), .dig_loop_o(dig_loop_o),
  .dual_loop_o(dual_loop_o), .all_ones_active_o(all_ones_active_o));
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcrb_regs.vh"

module tb_top;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clock_i = 1'b0, rst_n_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0, tick = 1'b0, ph;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, pc = 8'h00, rlb = 8'h00, los = 8'h00;
  logic [7:0] tp = 8'h00, tn = 8'h00, lrp = 8'h00, lrn = 8'h00, m;
  logic [47:0] e48;
  logic [7:0] msk [7] = '{8'h0f, 8'hff, 8'hff, 8'hff, 8'hfb, 8'h07, 8'hcf};
  int bt [6] = '{6, 5, 4, 3, 1, 0};
  int failures = 0, n_tests = 0;
  wire logic [7:0] rdata_o, rx_pos, rx_neg, ltp, ltn, dig, dual, c_ets, c_g775, c_t1, aoa;
  wire logic [7:0] alarm, shrt, ami, depth, jarx, jaen, e1, i120, rmo, trim, tto, trsv;
  wire logic [23:0] tcode;
  wire logic [3:0] mon_line;
  wire logic rd_hit_o, mon_act, mon_tx, rx_int;

  lcrb_config_bank #(.NCH(8), .DEFAULT_120(1)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rd_hit_o(rd_hit_o), .remote_loopback_bits_i(rlb),
    .per_channel_alarm_on_loss_i(pc), .per_channel_short_protect_off_i(pc), .per_channel_line_code_i(pc),
    .per_channel_ja_depth_i(pc), .per_channel_ja_position_i(pc), .per_channel_ja_enable_i(pc),
    .los_i(los), .mclk_tick_i(tick), .tx_pos_rail_i(tp), .tx_neg_rail_i(tn), .rx_pos_rail_o(rx_pos),
    .rx_neg_rail_o(rx_neg), .line_rx_pos_i(lrp), .line_rx_neg_i(lrn), .line_tx_pos_o(ltp),
    .line_tx_neg_o(ltn), .mon_active_o(mon_act), .mon_tx_line_o(mon_tx), .mon_line_o(mon_line),
    .dig_loop_o(dig), .dual_loop_o(dual), .crit_ets_o(c_ets), .crit_g775_o(c_g775), .crit_t1_o(c_t1),
    .all_ones_active_o(aoa), .rx_imp_internal_o(rx_int), .alarm_on_loss_o(alarm),
    .short_protect_off_o(shrt), .ami_select_o(ami), .ja_depth_128_o(depth), .ja_rx_path_o(jarx),
    .ja_enable_o(jaen), .e1_mode_o(e1), .imp_120_o(i120), .rx_match_off_o(rmo), .rx_trim_o(trim),
    .tx_term_off_o(tto), .tmpl_reserved_o(trsv), .tmpl_code_o(tcode));

  // ----------------------------------------
  // Host access and comparison tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Inputs change on the falling edge, so the rising edge sees them settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_i = a;
    wdata_i = d;
    wr_en_i = 1'b1;
    @(negedge clock_i);
    wr_en_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(negedge clock_i);
    addr_i = a;
    rd_en_i = 1'b1;
    @(negedge clock_i);
    rd_en_i = 1'b0;
    chk({rdata_o, rd_hit_o}, {exp, hit});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic pulse_tick;
    @(negedge clock_i);
    tick = 1'b1;
    @(negedge clock_i);
    tick = 1'b0;
  endtask
  // Channel i: code i, match-off on even, term-off on odd, alt impedance above 3
  function automatic logic [7:0] ts_val(input int i);
    return {~i[0], i[0], 2'b11, i[2], i[2:0]};
  endfunction
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Free-running clock
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #(100 * 20000);
    failures++;
    results();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge clock_i);
    rst_n_i = 1'b1;
    idle(2);
    for (int i = 0; i < 7; i++) rd(8'h0b + i[7:0], 8'h00, 1'b1);
    chk(trim, 8'h00);
    // Reserved bits drop, unmapped places miss
    foreach (msk[i]) begin
      wr(8'h0b + i[7:0], 8'hff);
      rd(8'h0b + i[7:0], msk[i], 1'b1);
      wr(8'h0b + i[7:0], 8'h00);
    end
    wr(8'h12, 8'hff);
    rd(8'h12, 8'h00, 1'b0);
    rd(8'h0a, 8'h00, 1'b0);
    // Eight template copies, every code once
    for (int i = 0; i < 8; i++) begin
      wr(`LCRB_ADDR_TPTR, i[7:0]);
      wr(`LCRB_ADDR_TSEL, ts_val(i));
    end
    idle(1);
    chk(tcode, 24'hfac688);
    chk({trsv, e1}, 16'h0601);
    chk({rmo, tto}, 16'h55aa);
    chk(trim, 8'haa);
    chk(i120, 8'h0f);
    chk({c_ets, c_g775, c_t1}, 24'h0001fe);
    wr(`LCRB_ADDR_LAC, 8'hff);
    idle(1);
    chk({c_ets, c_g775, c_t1}, 24'h0100fe);
    for (int i = 7; i >= 0; i--) begin
      wr(`LCRB_ADDR_TPTR, i[7:0]);
      rd(`LCRB_ADDR_TSEL, ts_val(i) & 8'hcf, 1'b1);
    end
    // Global overrides, one bit at a time, then none
    pc = 8'h5a;
    for (int k = 0; k < 7; k++) begin
      wr(`LCRB_ADDR_GLB, (k < 6) ? 8'h01 << bt[k] : 8'h00);
      idle(1);
      for (int j = 0; j < 6; j++) e48[47-8*j -: 8] = (j == k) ? 8'hff : 8'h5a;
      chk({alarm, shrt, ami, depth, jarx, jaen}, e48);
    end
    wr(`LCRB_ADDR_GLB, 8'h80);
    idle(1);
    chk({rx_int, trim}, 9'h100);
    wr(`LCRB_ADDR_GLB, 8'h00);
    // Monitor selection codes
    for (int c = 0; c < 16; c++) begin
      wr(`LCRB_ADDR_MON_CTRL, c[7:0]);
      idle(1);
      if (c[2:0] == 3'h0) chk({mon_act, mon_line}, 5'h00);
      else chk({mon_act, mon_tx, mon_line}, {1'b1, c[3], 4'h1 + c[2:0]});
    end
    // Digital, remote and dual loopback on chosen channels, then on all
    tp = 8'ha5;
    tn = 8'h3c;
    lrp = 8'h0f;
    lrn = 8'hf0;
    for (int k = 0; k < 2; k++) begin
      m = k ? 8'hff : 8'h81;
      rlb = k ? 8'hff : 8'h03;
      wr(`LCRB_ADDR_DLB, m);
      idle(5);
      chk({dig, dual}, {m, m & rlb});
      chk({rx_pos, rx_neg}, {(tp & m) | (lrp & ~m), (tn & m) | (lrn & ~m)});
      chk({ltp, ltn}, {(lrp & rlb) | (tp & ~rlb), (lrn & rlb) | (tn & ~rlb)});
    end
    rlb = 8'h00;
    wr(`LCRB_ADDR_DLB, 8'h00);
    // Automatic all-ones on loss, paced by the reference tick
    wr(`LCRB_ADDR_AAO, 8'h0f);
    los = 8'h33;
    idle(5);
    chk(aoa, 8'h03);
    chk({ltn[1:0], ltp[3:2]}, {~ltp[1:0], tp[3:2]});
    ph = ltp[0];
    idle(4);
    chk(ltp[0], ph);
    pulse_tick();
    idle(2);
    chk(ltp[0], {~ph});
    wr(`LCRB_ADDR_AAO, 8'hff);
    los = 8'hff;
    idle(5);
    chk(aoa, 8'hff);
    pulse_tick();
    idle(4);
    los = 8'h00;
    wr(`LCRB_ADDR_AAO, 8'h00);
    idle(5);
    chk(aoa, 8'h00);
    results();
  end
endmodule
`default_nettype wire
